// [core/axis_counter_cfg.svh]
// register offsets, config fields and reset values of the axis counter block
`ifndef AXIS_COUNTER_CFG_SVH
`define AXIS_COUNTER_CFG_SVH
`define OFS_CMD_POS 8'h00
`define OFS_FB_POS 8'h04
`define OFS_ERR_POS 8'h08
`define OFS_GP_CNT 8'h0C
`define OFS_CONFIG 8'h10
`define OFS_STATUS 8'h14
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 1
`define CFG_SRC_BIT 2
`define CFG_GP_LSB 3
`define CFG_GP_MSB 4
`define CFG_POL_BIT 5
`define CFG_W 6
`define CFG_RESET 6'h17
`define STS_INDEX_BIT 0
`define STS_PHASE_A_BIT 1
`define STS_PHASE_B_BIT 2
`define STS_ORIGIN_BIT 3
`endif

// [core/axis_counter_pkg.sv]
// types shared by the axis counter block
`default_nettype none
package axis_counter_pkg;
    typedef enum logic [1:0] {FB_UPDOWN, FB_X1, FB_X2, FB_X4} fb_mode_type;
    typedef enum logic [1:0] {GP_OUT, GP_FB, GP_MANUAL, GP_TIMEBASE} gp_src_type;
endpackage : axis_counter_pkg
`default_nettype wire

// [core/enc_decoder.sv]
// encoder phase decoder: up/down pulses or quadrature with 1x, 2x, 4x
`default_nettype none
module enc_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire axis_counter_pkg::fb_mode_type mode,
    output logic count_up,
    output logic count_dn
);
    logic a_reg, b_reg, up_reg, dn_reg;
    logic up_next, dn_next;
    logic a_rise, a_fall, b_rise, b_fall;

    always_comb begin
        a_rise = phase_a & ~a_reg;
        a_fall = ~phase_a & a_reg;
        b_rise = phase_b & ~b_reg;
        b_fall = ~phase_b & b_reg;
        up_next = 1'b0;
        dn_next = 1'b0;
        case (mode)
            axis_counter_pkg::FB_UPDOWN: begin
                up_next = a_rise; // [R7]
                dn_next = b_rise; // [R7]
            end
            axis_counter_pkg::FB_X1: begin
                up_next = a_rise & ~phase_b & ~b_rise & ~b_fall; // [R8]
                dn_next = a_fall & ~phase_b & ~b_rise & ~b_fall; // [R8]
            end
            default: begin
                // a and b moving together is a glitch, not a count
                if (!(b_rise || b_fall)) begin
                    up_next = (a_rise & ~phase_b) | (a_fall & phase_b); // [R8]
                    dn_next = (a_rise & phase_b) | (a_fall & ~phase_b); // [R8]
                end else if (mode == axis_counter_pkg::FB_X4 && !(a_rise || a_fall)) begin
                    up_next = (b_rise & phase_a) | (b_fall & ~phase_a); // [R6]
                    dn_next = (b_rise & ~phase_a) | (b_fall & phase_a); // [R6]
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_reg <= 1'b0;
            b_reg <= 1'b0;
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else begin
            a_reg <= phase_a;
            b_reg <= phase_b;
            up_reg <= up_next;
            dn_reg <= dn_next;
        end
    end

    assign count_up = up_reg;
    assign count_dn = dn_reg;

    a_updown_up: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        (mode == axis_counter_pkg::FB_UPDOWN && phase_a && !a_reg) |=> count_up)
        else $error("up/down mode missed a phase a pulse");
    a_quad_lead: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        (mode == axis_counter_pkg::FB_X4 && !a_reg && !b_reg && phase_a && !phase_b)
        |=> count_up && !count_dn)
        else $error("leading phase a did not count up");
endmodule : enc_decoder
`default_nettype wire

// [core/axis_position_counters.sv]
// per-axis command, feedback, position error and general counters on apb
//
// Summary of operation
// (R1) 28-bit command counter follows emitted pulses
// (R2) command counter moves only on pulses
// (R3) home completion zeroes command counter
// (R4) software reads and writes command counter anytime
// (R5) 28-bit feedback counter from encoder phases
// (R6) up/down or quadrature 1x/2x/4x decoding
// (R7) up/down mode: phase a up, b down
// (R8) quadrature: a leads counts up, lags down
// (R9) feedback source: encoder (1) or own pulses
// (R10) feedback counter: home clears, software reads/writes
// (R11) index polarity programmable, level readable
// (R12) error counter: out pulse up, feedback down
// (R13) error counter readable, software and home clear
// (R14) general counter source: out, feedback, manual, clk/2
// (R15) general counter source resets to manual pulser
// (R16) software loads and reads general counter
// (R17) software keeps its own target position record
// (R18) software reloads target after home or write
// (R19) counters wrap, read back sign-extended
// (R20) software write beats a same-cycle count
//
// Design decisions made here: the APB register port and the placing of the registers.
`include "axis_counter_cfg.svh"
`default_nettype none
module axis_position_counters #(
    parameter int CNT_W = 28
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PULSE_OUT,
    input wire logic PULSE_DIR,
    input wire logic HOME_DONE,
    input wire logic ENC_PHASE_A,
    input wire logic ENC_PHASE_B,
    input wire logic ENC_INDEX,
    input wire logic ORIGIN_SENSOR,
    input wire logic MANUAL_PULSE,
    input wire logic MANUAL_DIR,
    output logic INDEX_ACTIVE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    // ---------------- apb slave ----------------
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic [`CFG_W-1:0] cfg_reg, cfg_next;
    logic [CNT_W-1:0] cmd_reg, cmd_next, fb_reg, fb_next;
    logic [CNT_W-1:0] err_reg, err_next, gp_reg, gp_next;
    logic idx_reg, idx_next, tb_reg, tb_next;
    logic wr_acc, wr_cmd, wr_fb, wr_err, wr_gp, wr_cfg, mapped;
    logic [31:0] status_word;
    axis_counter_pkg::fb_mode_type fb_mode;
    axis_counter_pkg::gp_src_type gp_src;
    logic enc_up, enc_dn, fb_up, fb_dn, gp_up, gp_dn;

    function automatic logic [31:0] sext(input logic [CNT_W-1:0] v);
        sext = {{(32-CNT_W){v[CNT_W-1]}}, v}; // [R19]
    endfunction : sext

    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v,
                                               input logic up, input logic dn);
        // wraps modulo 2**CNT_W; up and down together cancel
        if (up && !dn) begin
            step = v + CNT_W'(1); // [R19]
        end else if (dn && !up) begin
            step = v - CNT_W'(1); // [R19]
        end else begin
            step = v;
        end
    endfunction : step

    always_comb begin
        mapped = (PADDR == `OFS_CMD_POS) || (PADDR == `OFS_FB_POS) ||
                 (PADDR == `OFS_ERR_POS) || (PADDR == `OFS_GP_CNT) ||
                 (PADDR == `OFS_CONFIG) || (PADDR == `OFS_STATUS);
        wr_acc = PSEL && PENABLE && pready_reg && PWRITE;
        wr_cmd = wr_acc && (PADDR == `OFS_CMD_POS);
        wr_fb = wr_acc && (PADDR == `OFS_FB_POS);
        wr_err = wr_acc && (PADDR == `OFS_ERR_POS);
        wr_gp = wr_acc && (PADDR == `OFS_GP_CNT);
        wr_cfg = wr_acc && (PADDR == `OFS_CONFIG);
        status_word = 32'h0000_0000;
        status_word[`STS_INDEX_BIT] = idx_reg; // [R11]
        status_word[`STS_PHASE_A_BIT] = ENC_PHASE_A;
        status_word[`STS_PHASE_B_BIT] = ENC_PHASE_B;
        status_word[`STS_ORIGIN_BIT] = ORIGIN_SENSOR;
        // no wait state: data and ready are set up in the setup cycle
        pready_next = PSEL && !PENABLE;
        pslverr_next = PSEL && !PENABLE && !mapped;
        prdata_next = 32'h0000_0000;
        if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                `OFS_CMD_POS: prdata_next = sext(cmd_reg); // [R4]
                `OFS_FB_POS: prdata_next = sext(fb_reg); // [R10]
                `OFS_ERR_POS: prdata_next = sext(err_reg); // [R13]
                `OFS_GP_CNT: prdata_next = sext(gp_reg); // [R16]
                `OFS_CONFIG: prdata_next = {{(32-`CFG_W){1'b0}}, cfg_reg};
                `OFS_STATUS: prdata_next = status_word;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        cfg_next = wr_cfg ? PWDATA[`CFG_W-1:0] : cfg_reg;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            cfg_reg <= `CFG_RESET; // [R15]
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            cfg_reg <= cfg_next;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign INDEX_ACTIVE = idx_reg;

    // ---------------- encoder decode ----------------
    assign fb_mode = axis_counter_pkg::fb_mode_type'(cfg_reg[`CFG_MODE_MSB:`CFG_MODE_LSB]);
    assign gp_src = axis_counter_pkg::gp_src_type'(cfg_reg[`CFG_GP_MSB:`CFG_GP_LSB]);

    enc_decoder u_dec (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .phase_a(ENC_PHASE_A),
        .phase_b(ENC_PHASE_B),
        .mode(fb_mode), // [R6]
        .count_up(enc_up),
        .count_dn(enc_dn)
    );

    // ---------------- counters ----------------
    always_comb begin
        // source 1 counts encoder inputs, 0 mirrors the command pulses
        if (cfg_reg[`CFG_SRC_BIT]) begin
            fb_up = enc_up; // [R9]
            fb_dn = enc_dn; // [R9]
        end else begin
            fb_up = PULSE_OUT && PULSE_DIR; // [R9]
            fb_dn = PULSE_OUT && !PULSE_DIR; // [R9]
        end
        case (gp_src)
            axis_counter_pkg::GP_OUT: begin
                gp_up = PULSE_OUT && PULSE_DIR; // [R14]
                gp_dn = PULSE_OUT && !PULSE_DIR;
            end
            axis_counter_pkg::GP_FB: begin
                gp_up = fb_up; // [R14]
                gp_dn = fb_dn;
            end
            axis_counter_pkg::GP_MANUAL: begin
                gp_up = MANUAL_PULSE && MANUAL_DIR; // [R14]
                gp_dn = MANUAL_PULSE && !MANUAL_DIR;
            end
            default: begin
                gp_up = tb_reg; // [R14]
                gp_dn = 1'b0;
            end
        endcase
        tb_next = !tb_reg;
        idx_next = ENC_INDEX ^ cfg_reg[`CFG_POL_BIT]; // [R11]
        // write first, then home clear, then the count of this cycle
        if (wr_cmd) begin
            cmd_next = PWDATA[CNT_W-1:0]; // [R4] [R20]
        end else if (HOME_DONE) begin
            cmd_next = '0; // [R3]
        end else begin
            cmd_next = step(cmd_reg, PULSE_OUT && PULSE_DIR, PULSE_OUT && !PULSE_DIR); // [R1] [R2]
        end
        if (wr_fb) begin
            fb_next = PWDATA[CNT_W-1:0]; // [R10] [R20]
        end else if (HOME_DONE) begin
            fb_next = '0; // [R10]
        end else begin
            fb_next = step(fb_reg, fb_up, fb_dn); // [R5]
        end
        if (wr_err || HOME_DONE) begin
            err_next = '0; // [R13]
        end else begin
            err_next = step(err_reg, PULSE_OUT, enc_up || enc_dn); // [R12]
        end
        if (wr_gp) begin
            gp_next = PWDATA[CNT_W-1:0]; // [R16] [R20]
        end else begin
            gp_next = step(gp_reg, gp_up, gp_dn);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmd_reg <= '0;
            fb_reg <= '0;
            err_reg <= '0;
            gp_reg <= '0;
            tb_reg <= 1'b0;
            idx_reg <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
            fb_reg <= fb_next;
            err_reg <= err_next;
            gp_reg <= gp_next;
            tb_reg <= tb_next;
            idx_reg <= idx_next;
        end
    end

    // ---------------- checks ----------------
    logic cfg_touched_reg;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_touched_reg <= 1'b0;
        end else if (wr_cfg) begin
            cfg_touched_reg <= 1'b1;
        end
    end

    sequence quiet_gp;
        !wr_gp && !wr_cfg;
    endsequence

    a_cmd_pulse_up: assert property ( // [R1]
        PULSE_OUT && PULSE_DIR && !wr_cmd && !HOME_DONE |=> cmd_reg == $past(cmd_reg) + CNT_W'(1))
        else $error("command counter missed an up pulse");
    a_cmd_no_pulse: assert property ( // [R2]
        !PULSE_OUT && !wr_cmd && !HOME_DONE |=> $stable(cmd_reg))
        else $error("command counter moved without a pulse");
    a_cmd_home_zero: assert property ( // [R3]
        HOME_DONE && !wr_cmd |=> cmd_reg == '0)
        else $error("home completion did not clear command counter");
    a_cmd_write_wins: assert property ( // [R20]
        wr_cmd && PULSE_OUT |=> cmd_reg == $past(PWDATA[CNT_W-1:0]))
        else $error("write lost against a count");
    a_fb_home_zero: assert property ( // [R10]
        HOME_DONE && !wr_fb |=> fb_reg == '0)
        else $error("home completion did not clear feedback counter");
    a_fb_mirror: assert property ( // [R9]
        !cfg_reg[`CFG_SRC_BIT] && PULSE_OUT && !PULSE_DIR && !wr_fb && !HOME_DONE
        |=> fb_reg == $past(fb_reg) - CNT_W'(1))
        else $error("feedback counter did not follow output pulse");
    a_err_balance: assert property ( // [R12]
        PULSE_OUT && !enc_up && !enc_dn && !wr_err && !HOME_DONE
        |=> err_reg == $past(err_reg) + CNT_W'(1))
        else $error("error counter missed an output pulse");
    a_err_clear: assert property ( // [R13]
        wr_err ##1 !HOME_DONE && !wr_err && !PULSE_OUT && !enc_up && !enc_dn
        |=> err_reg == '0)
        else $error("error counter not cleared by software");
    a_gp_timebase: assert property ( // [R14]
        gp_src == axis_counter_pkg::GP_TIMEBASE ##0 quiet_gp ##1 quiet_gp
        |=> gp_reg == $past(gp_reg, 2) + CNT_W'(1))
        else $error("timebase source not counting at half clock");
    a_gp_default: assert property ( // [R15]
        !cfg_touched_reg |-> gp_src == axis_counter_pkg::GP_MANUAL)
        else $error("general counter source not manual after reset");
    a_index_level: assert property ( // [R11]
        INDEX_ACTIVE == $past(ENC_INDEX ^ cfg_reg[`CFG_POL_BIT]))
        else $error("index status does not follow polarity");
    a_read_sext: assert property ( // [R19]
        PSEL && !PENABLE && !PWRITE && PADDR == `OFS_CMD_POS && !wr_acc
        |=> PRDATA == {{(32-CNT_W){$past(cmd_reg[CNT_W-1])}}, $past(cmd_reg)})
        else $error("command read not sign-extended");
    a_cmd_pulse_down: assert property ( // [R1]
        PULSE_OUT && !PULSE_DIR && !wr_cmd && !HOME_DONE
        |=> cmd_reg == $past(cmd_reg) - CNT_W'(1))
        else $error("command counter missed a down pulse");
    a_fb_enc_up: assert property ( // [R5]
        cfg_reg[`CFG_SRC_BIT] && enc_up && !enc_dn && !wr_fb && !HOME_DONE
        |=> fb_reg == $past(fb_reg) + CNT_W'(1))
        else $error("feedback counter missed an encoder count");
    // software writes replace the whole value; a same-cycle count is lost
    a_fb_write_wins: assert property ( // [R20]
        wr_fb |=> fb_reg == $past(PWDATA[CNT_W-1:0]))
        else $error("feedback write did not land");
    a_gp_write_load: assert property ( // [R16]
        wr_gp |=> gp_reg == $past(PWDATA[CNT_W-1:0]))
        else $error("general counter write did not land");
    a_err_home_zero: assert property ( // [R13]
        HOME_DONE |=> err_reg == '0)
        else $error("home completion did not clear error counter");
    a_gp_manual_up: assert property ( // [R14]
        gp_src == axis_counter_pkg::GP_MANUAL && MANUAL_PULSE && MANUAL_DIR && !wr_gp
        |=> gp_reg == $past(gp_reg) + CNT_W'(1))
        else $error("general counter missed a manual pulse");
endmodule : axis_position_counters
`default_nettype wire

// [tb/axis_far_model.sv]
// far side of the axis counters: encoder phases, pulse generator, manual pulser
`default_nettype none
module axis_far_model (
    input wire logic clk,
    output logic phase_a,
    output logic phase_b,
    output logic pulse,
    output logic dir,
    output logic man_pulse,
    output logic man_dir
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {phase_a, phase_b, pulse, dir, man_pulse, man_dir} = 6'h00;
    // one gray step, a leads b going up; dwell covers the decoder latency
    task automatic quad(input logic up);
        @(posedge clk);
        {phase_a, phase_b} <= up ? {~phase_b, phase_a} : {phase_b, ~phase_a};
        repeat (3) @(posedge clk);
    endtask : quad
    // only one phase moves per cycle, both rising at once would give an up and a down count together
    task automatic updn(input logic on_a);
        @(posedge clk);
        {phase_a, phase_b} <= {on_a, ~on_a};
        repeat (2) @(posedge clk);
        {phase_a, phase_b} <= 2'h0;
        repeat (2) @(posedge clk);
    endtask : updn
    task automatic strobe(input logic manual, input logic up);
        @(posedge clk);
        pulse <= ~manual;
        man_pulse <= manual;
        dir <= up;
        man_dir <= up;
        @(posedge clk);
        pulse <= 1'b0;
        man_pulse <= 1'b0;
    endtask : strobe
endmodule : axis_far_model
`default_nettype wire

// [tb/axis_position_counters_bench.sv]
// bench for the axis position counters: apb tasks and one task per scenario
`include "axis_counter_cfg.svh"
`default_nettype none
module axis_position_counters_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic home = 1'b0;
    logic ez = 1'b0;
    logic origin_sensor = 1'b0;
    logic idx_act;
    wire logic pa, pb, po, pd, mp, md;
    int errors = 0;
    int n_compared = 0;
    int target = 0;
    always #25 clk = ~clk;
    axis_far_model i_axis_far_model (.clk(clk), .phase_a(pa), .phase_b(pb), .pulse(po),
        .dir(pd), .man_pulse(mp), .man_dir(md));
    axis_position_counters i_axis_position_counters (.SYS_CLK(clk), .RESET_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PULSE_OUT(po), .PULSE_DIR(pd),
        .HOME_DONE(home), .ENC_PHASE_A(pa), .ENC_PHASE_B(pb), .ENC_INDEX(ez),
        .ORIGIN_SENSOR(origin_sensor), .MANUAL_PULSE(mp), .MANUAL_DIR(md), .INDEX_ACTIVE(idx_act));
    task automatic test_done;
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    // ready, data and error are taken at the edge that sees ready high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cmp({31'h0000_0000, pready !== 1'b1}, 32'h0000_0000);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        cmp(r, exp);
        cmp({31'h0000_0000, e}, {31'h0000_0000, a > 8'h14});
    endtask : chk
    task automatic t_reset;
        chk(`OFS_CONFIG, 32'h0000_0017);
        chk(`OFS_CMD_POS, 32'h0000_0000);
        chk(8'h18, 32'h0000_0000);
    endtask : t_reset
    task automatic t_cmd;
        repeat (3) i_axis_far_model.strobe(1'b0, 1'b1);
        target += 3;
        chk(`OFS_CMD_POS, 32'(target));
        chk(`OFS_ERR_POS, 32'h0000_0003);
        chk(`OFS_FB_POS, 32'h0000_0000);
        repeat (5) i_axis_far_model.strobe(1'b0, 1'b0);
        chk(`OFS_CMD_POS, 32'hFFFF_FFFE);
    endtask : t_cmd
    task automatic t_write;
        wr(`OFS_CMD_POS, 32'h0FFF_FFFF);
        chk(`OFS_CMD_POS, 32'hFFFF_FFFF);
        i_axis_far_model.strobe(1'b0, 1'b1);
        chk(`OFS_CMD_POS, 32'h0000_0000);
        wr(`OFS_FB_POS, 32'h0800_0000);
        chk(`OFS_FB_POS, 32'hF800_0000);
        wr(`OFS_GP_CNT, 32'h0000_0123);
        chk(`OFS_GP_CNT, 32'h0000_0123);
        fork
            wr(`OFS_CMD_POS, 32'h0000_0064);
            begin
                @(posedge clk);
                i_axis_far_model.strobe(1'b0, 1'b1);
            end
        join
        chk(`OFS_CMD_POS, 32'h0000_0064);
    endtask : t_write
    task automatic t_quad;
        int k;
        for (int m = 1; m < 4; m++) begin
            k = 1 << (m - 1);
            wr(`OFS_CONFIG, 32'h0000_0014 | 32'(m));
            wr(`OFS_FB_POS, 32'h0000_0000);
            wr(`OFS_ERR_POS, 32'h0000_0000);
            repeat (8) i_axis_far_model.quad(1'b1);
            chk(`OFS_FB_POS, 32'(2 * k));
            chk(`OFS_ERR_POS, -32'(2 * k));
            repeat (4) i_axis_far_model.quad(1'b0);
            chk(`OFS_FB_POS, 32'(k));
        end
        i_axis_far_model.strobe(1'b0, 1'b1);
        @(posedge clk);
        home <= 1'b1;
        @(posedge clk);
        home <= 1'b0;
        target = 0;
        chk(`OFS_CMD_POS, 32'(target));
        chk(`OFS_FB_POS, 32'h0000_0000);
        chk(`OFS_ERR_POS, 32'h0000_0000);
    endtask : t_quad
    task automatic t_updn;
        wr(`OFS_CONFIG, 32'h0000_0014);
        repeat (3) i_axis_far_model.updn(1'b1);
        i_axis_far_model.updn(1'b0);
        chk(`OFS_FB_POS, 32'h0000_0002);
        repeat (3) i_axis_far_model.strobe(1'b1, 1'b1);
        chk(`OFS_GP_CNT, 32'h0000_0126);
        wr(`OFS_CONFIG, 32'h0000_0010);
        repeat (2) i_axis_far_model.strobe(1'b0, 1'b1);
        chk(`OFS_FB_POS, 32'h0000_0004);
    endtask : t_updn
    task automatic t_gp;
        logic [31:0] r;
        logic e;
        wr(`OFS_CONFIG, 32'h0000_0004);
        wr(`OFS_GP_CNT, 32'h0000_0000);
        repeat (2) i_axis_far_model.strobe(1'b0, 1'b1);
        chk(`OFS_GP_CNT, 32'h0000_0002);
        wr(`OFS_CONFIG, 32'h0000_000C);
        repeat (2) i_axis_far_model.updn(1'b1);
        chk(`OFS_GP_CNT, 32'h0000_0004);
        wr(`OFS_CONFIG, 32'h0000_001C);
        wr(`OFS_GP_CNT, 32'h0000_0000);
        repeat (20) @(posedge clk);
        apb(1'b0, `OFS_GP_CNT, 32'h0000_0000, r, e);
        cmp({31'h0000_0000, r > 32'h0000_0009 && r < 32'h0000_000E}, 32'h0000_0001);
    endtask : t_gp
    task automatic t_index;
        @(posedge clk);
        ez <= 1'b1;
        origin_sensor <= 1'b1;
        repeat (3) @(negedge clk);
        cmp({31'h0000_0000, idx_act}, 32'h0000_0001);
        chk(`OFS_STATUS, 32'h0000_0009);
        wr(`OFS_CONFIG, 32'h0000_0034);
        repeat (2) @(negedge clk);
        cmp({31'h0000_0000, idx_act}, 32'h0000_0000);
        chk(`OFS_STATUS, 32'h0000_0008);
    endtask : t_index
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_cmd();
        t_write();
        t_quad();
        t_updn();
        t_gp();
        t_index();
        test_done();
    end
    // about fifty times the expected run
    initial begin
        #1_000_000;
        errors++;
        test_done();
    end
endmodule : axis_position_counters_bench
`default_nettype wire
